// ### common/fcl_pkg.sv
// shared constants and types for the flash configuration page loader
package fcl_pkg;

  // ---------------------------------------------------------------
  // flash organisation
  // ---------------------------------------------------------------
  localparam int PAGE_BYTES = 512;
  localparam int MAIN_PAGES = 32;
  localparam int CODE_BYTES = 16384;
  localparam int DATA_BYTES = 1536;
  localparam int EE_BYTES = 512;
  localparam int MB_ADDR_W = 15;
  localparam int CFG_ADDR_W = 9;
  localparam int PAGE_LSB = 9;
  localparam int PAGE_MSB = 13;

  // ---------------------------------------------------------------
  // configuration page layout
  // ---------------------------------------------------------------
  localparam logic [8:0] OFS_PARAM_AREA = 9'h000;
  localparam int PARAM_AREA_BYTES = 32;
  localparam logic [8:0] OFS_UPC = 9'h020;
  localparam logic [8:0] OFS_RSVD_A = 9'h021;
  localparam logic [8:0] OFS_RDIS = 9'h023;
  localparam logic [8:0] OFS_DBG = 9'h024;
  localparam logic [8:0] OFS_RSVD_B = 9'h025;

  // ---------------------------------------------------------------
  // byte values and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam logic [7:0] RDIS_SET_VAL = 8'h00;
  localparam logic [7:0] MAIN_PAGES_B = 8'h20;
  // safe values until their byte is read: all protected, locked, no debug
  localparam logic [7:0] RST_UPC = 8'h00;
  localparam logic [7:0] RST_RDIS = 8'h00;
  localparam logic [7:0] RST_DBG = 8'hFF;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_UPC = 4'h1,
    ST_RDIS = 4'h2,
    ST_DBG = 4'h4,
    ST_RUN = 4'h8
  } fcl_state_t;

  typedef enum logic [2:0] {
    SPI_READ = 3'h0,
    SPI_WRITE = 3'h1,
    SPI_ERASE_PAGE = 3'h2,
    SPI_SET_RDIS = 3'h3,
    SPI_ERASE_ALL = 3'h4
  } fcl_spi_op_t;

  typedef struct packed {
    logic valid;
    logic erase;
    logic [14:0] addr;
  } fcl_cpu_req_t;

  typedef struct packed {
    logic valid;
    fcl_spi_op_t op;
    logic info;
    logic [14:0] addr;
  } fcl_spi_req_t;

  typedef struct packed {
    logic grant;
    logic deny;
  } fcl_resp_t;

endpackage

// ### rtl/fcl_loader.sv
// configuration page loader with processor and programmer access gating

// Notes on behaviour
// - main block: 32 pages, 512 bytes each
// - 16k code, 1.5k data, 512 extended
// - every reset: load configuration page into registers
// - load count byte at 0x20; 0xFF unprotects all
// - count below 32 is first protected page
// - deny processor erase/write in protected area
// - programmer may still access protected area
// - readback disable not 0xFF blocks main block
// - readback disable set once; erase-all restores
// - debug byte 0xFF keeps debug, JTAG off
module fcl_loader (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  output logic cfg_rd_req_o,
  output logic [8:0] cfg_rd_addr_o,
  input wire logic [7:0] cfg_rd_data_i,
  input wire logic cfg_rd_valid_i,
  input wire fcl_pkg::fcl_cpu_req_t cpu_req_i,
  output fcl_pkg::fcl_resp_t cpu_resp_o,
  input wire fcl_pkg::fcl_spi_req_t spi_req_i,
  output fcl_pkg::fcl_resp_t spi_resp_o,
  output logic [7:0] protection_config_reg_o,
  output logic readback_disabled_o,
  output logic debug_en_o,
  output logic jtag_en_o,
  output logic cfg_loaded_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    fcl_pkg::fcl_state_t fsm;
    logic rd_req;
    logic [8:0] rd_addr;
    logic [7:0] upc;
    logic [7:0] rdis;
    logic [7:0] dbg;
    logic dbg_on;
    logic locked;
    logic loaded;
    fcl_pkg::fcl_resp_t cpu_resp;
    fcl_pkg::fcl_resp_t spi_resp;
  } fcl_loader_state_t;

  localparam fcl_loader_state_t RST_STATE = '{
    fsm: fcl_pkg::ST_UPC,
    rd_req: 1'b1,
    rd_addr: fcl_pkg::OFS_UPC,
    upc: fcl_pkg::RST_UPC,
    rdis: fcl_pkg::RST_RDIS,
    dbg: fcl_pkg::RST_DBG,
    dbg_on: 1'b0,
    locked: 1'b1,
    loaded: 1'b0,
    cpu_resp: '0,
    spi_resp: '0
  };

  fcl_loader_state_t s;
  fcl_loader_state_t next_s;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic cpu_in_code;
  logic [7:0] cpu_page;
  logic cpu_protected;
  logic cpu_take;
  logic spi_take;
  logic spi_mb_open;

  assign cpu_in_code = cpu_req_i.addr < 15'(fcl_pkg::CODE_BYTES);
  assign cpu_page = {3'h0, cpu_req_i.addr[fcl_pkg::PAGE_MSB:fcl_pkg::PAGE_LSB]};
  // only a count below the page total splits the code space
  assign cpu_protected = cpu_in_code && (s.upc < fcl_pkg::MAIN_PAGES_B)
                         && (cpu_page >= s.upc);
  // a response pending means the requester still holds its old request
  assign cpu_take = s.loaded && cpu_req_i.valid && !(|s.cpu_resp);
  assign spi_take = s.loaded && spi_req_i.valid && !(|s.spi_resp);
  assign spi_mb_open = (s.rdis == fcl_pkg::BYTE_ERASED);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.cpu_resp = '0;
    next_s.spi_resp = '0;
    unique case (s.fsm)
      fcl_pkg::ST_UPC: begin
        if (cfg_rd_valid_i) begin
          next_s.upc = cfg_rd_data_i;
          next_s.rd_addr = fcl_pkg::OFS_RDIS;
          next_s.fsm = fcl_pkg::ST_RDIS;
        end
      end
      fcl_pkg::ST_RDIS: begin
        if (cfg_rd_valid_i) begin
          next_s.rdis = cfg_rd_data_i;
          next_s.rd_addr = fcl_pkg::OFS_DBG;
          next_s.fsm = fcl_pkg::ST_DBG;
        end
      end
      fcl_pkg::ST_DBG: begin
        if (cfg_rd_valid_i) begin
          next_s.dbg = cfg_rd_data_i;
          next_s.rd_req = 1'b0;
          next_s.loaded = 1'b1;
          next_s.fsm = fcl_pkg::ST_RUN;
        end
      end
      fcl_pkg::ST_RUN: begin
        if (cpu_take) begin
          next_s.cpu_resp.grant = !cpu_protected;
          next_s.cpu_resp.deny = cpu_protected;
        end
        if (spi_take) begin
          unique case (spi_req_i.op)
            fcl_pkg::SPI_READ: begin
              // configuration page stays readable even when locked
              next_s.spi_resp.grant = spi_req_i.info || spi_mb_open;
              next_s.spi_resp.deny = !(spi_req_i.info || spi_mb_open);
            end
            fcl_pkg::SPI_WRITE,
            fcl_pkg::SPI_ERASE_PAGE: begin
              // protection count is ignored on this path
              next_s.spi_resp.grant = spi_mb_open;
              next_s.spi_resp.deny = !spi_mb_open;
            end
            fcl_pkg::SPI_SET_RDIS: begin
              next_s.spi_resp.grant = spi_mb_open;
              next_s.spi_resp.deny = !spi_mb_open;
              if (spi_mb_open) begin
                next_s.rdis = fcl_pkg::RDIS_SET_VAL;
              end
            end
            fcl_pkg::SPI_ERASE_ALL: begin
              // the count, readback disable and debug bytes all read erased afterwards
              next_s.spi_resp.grant = 1'b1;
              next_s.upc = fcl_pkg::BYTE_ERASED;
              next_s.rdis = fcl_pkg::BYTE_ERASED;
              next_s.dbg = fcl_pkg::BYTE_ERASED;
            end
            default: begin
              next_s.spi_resp.deny = 1'b1;
            end
          endcase
        end
      end
    endcase
    next_s.dbg_on = next_s.loaded && (next_s.dbg != fcl_pkg::BYTE_ERASED);
    next_s.locked = (next_s.rdis != fcl_pkg::BYTE_ERASED);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cfg_rd_req_o = s.rd_req;
  assign cfg_rd_addr_o = s.rd_addr;
  assign cpu_resp_o = s.cpu_resp;
  assign spi_resp_o = s.spi_resp;
  assign protection_config_reg_o = s.upc;
  assign readback_disabled_o = s.locked;
  assign debug_en_o = s.dbg_on;
  assign jtag_en_o = s.dbg_on;
  assign cfg_loaded_o = s.loaded;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence last_byte_s;
    s.fsm == fcl_pkg::ST_DBG && cfg_rd_valid_i;
  endsequence

  sequence first_byte_s;
    s.fsm == fcl_pkg::ST_UPC && cfg_rd_valid_i;
  endsequence

  load_order_a: assert property (first_byte_s |=> s.fsm == fcl_pkg::ST_RDIS
    && cfg_rd_addr_o == fcl_pkg::OFS_RDIS && protection_config_reg_o == $past(cfg_rd_data_i))
    else $error("count byte not captured in order");

  load_done_a: assert property (last_byte_s |=> cfg_loaded_o && !cfg_rd_req_o)
    else $error("load did not finish after last byte");

  hold_off_a: assert property (!cfg_loaded_o |=> !(|cpu_resp_o) && !(|spi_resp_o))
    else $error("access answered before load");

  cpu_prot_a: assert property (cpu_take && cpu_in_code && s.upc < 8'h20
    && cpu_page >= s.upc |=> cpu_resp_o.deny && !cpu_resp_o.grant)
    else $error("protected page not refused");

  cpu_free_a: assert property (cpu_take && s.upc == 8'hFF |=> cpu_resp_o.grant)
    else $error("unprotected write refused");

  mb_locked_a: assert property (spi_take && !spi_req_i.info && s.rdis != 8'hFF
    && spi_req_i.op inside {fcl_pkg::SPI_READ, fcl_pkg::SPI_WRITE}
    |=> spi_resp_o.deny)
    else $error("locked main block access allowed");

  rdis_once_a: assert property (s.loaded && s.rdis != 8'hFF ##1 $changed(s.rdis)
    |-> s.rdis == 8'hFF && $past(spi_req_i.op) == fcl_pkg::SPI_ERASE_ALL)
    else $error("readback byte changed twice");

  dbg_map_a: assert property (last_byte_s ##0 (cfg_rd_data_i == 8'hFF)
    |=> (!debug_en_o && !jtag_en_o) [*2])
    else $error("debug enabled by erased byte");

endmodule

// ### bench/fcl_page_model.sv
// configuration page store answering the loader's start-up reads
module fcl_page_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [8:0] addr_i,
  input wire logic slow_i,
  input wire logic [7:0] upc_i,
  input wire logic [7:0] rdis_i,
  input wire logic [7:0] dbg_i,
  output logic [7:0] data_o,
  output logic valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int gap = 0;

  function automatic logic [7:0] page_byte(logic [8:0] a);
    if (a < 9'h020) return 8'h5A;
    case (a)
      9'h020: return upc_i;
      9'h023: return rdis_i;
      9'h024: return dbg_i;
      default: return 8'hFF;
    endcase
  endfunction

  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
  end

  // data toggles outside its valid cycle so a late sample cannot pass
  always @(posedge clk_i) begin
    data_o <= ~data_o;
    valid_o <= 1'b0;
    if (gap > 0) begin
      gap <= gap - 1;
    end else if (req_i && !valid_o) begin
      valid_o <= 1'b1;
      data_o <= page_byte(addr_i);
      gap <= slow_i ? 3 : 0;
    end
  end
endmodule

// ### bench/fcl_loader_tb_top.sv
// self-checking bench for the configuration page loader
module fcl_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic rd_req, rd_valid, rdis_o, dbg_en, jtag_en, loaded;
  logic [8:0] rd_addr;
  logic [7:0] rd_data, prot;
  logic [7:0] upc = 8'hFF;
  logic [7:0] rdis = 8'hFF;
  logic [7:0] dbg = 8'hFF;
  fcl_pkg::fcl_cpu_req_t cpu = '0;
  fcl_pkg::fcl_spi_req_t spi = '0;
  fcl_pkg::fcl_resp_t cpu_r, spi_r;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  fcl_loader u_dut (.ref_clk_i(clk), .rstn_i(rstn), .cfg_rd_req_o(rd_req),
    .cfg_rd_addr_o(rd_addr), .cfg_rd_data_i(rd_data), .cfg_rd_valid_i(rd_valid),
    .cpu_req_i(cpu), .cpu_resp_o(cpu_r), .spi_req_i(spi), .spi_resp_o(spi_r),
    .protection_config_reg_o(prot), .readback_disabled_o(rdis_o), .debug_en_o(dbg_en),
    .jtag_en_o(jtag_en), .cfg_loaded_o(loaded));

  fcl_page_model u_page (.clk_i(clk), .req_i(rd_req), .addr_i(rd_addr), .slow_i(slow),
    .upc_i(upc), .rdis_i(rdis), .dbg_i(dbg), .data_o(rd_data), .valid_o(rd_valid));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic boot(logic [7:0] n, logic [7:0] r, logic [7:0] d, logic s);
    // page image as the programmer left it over the serial link
    upc = n;
    rdis = r;
    dbg = d;
    slow = s;
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
  endtask

  // bounded wait for a response pulse, then release the request
  task automatic wait_resp();
    int i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while ((cpu_r.grant | cpu_r.deny | spi_r.grant | spi_r.deny) !== 1'b1 && i < 60);
    cpu.valid = 1'b0;
    spi.valid = 1'b0;
    chk(loaded, 1);
  endtask

  // op bit 0 doubles as the processor erase flag
  task automatic xfer(logic is_spi, fcl_pkg::fcl_spi_op_t op, logic info,
                      logic [14:0] a, logic exp);
    @(posedge clk);
    #1;
    if (is_spi) spi = '{1'b1, op, info, a};
    else cpu = '{1'b1, op[0], a};
    wait_resp();
    // both bits compared so a missing answer cannot pass as a refusal
    chk(is_spi ? {spi_r.grant, spi_r.deny} : {cpu_r.grant, cpu_r.deny}, {exp, !exp});
  endtask

  task automatic test_prot();
    boot(8'h0C, 8'hFF, 8'hFF, 1'b0);
    xfer(0, fcl_pkg::SPI_WRITE, 0, 15'h17FF, 1);
    chk(prot, 8'h0C);
    chk({rdis_o, dbg_en, jtag_en}, 0);
    xfer(0, fcl_pkg::SPI_WRITE, 0, 15'h1800, 0);
    xfer(0, fcl_pkg::SPI_READ, 0, 15'h3FFF, 0);
    xfer(0, fcl_pkg::SPI_WRITE, 0, 15'h4000, 1);
    xfer(1, fcl_pkg::SPI_ERASE_PAGE, 0, 15'h1800, 1);
    xfer(1, fcl_pkg::SPI_WRITE, 0, 15'h3E00, 1);
    $display("test_prot done");
  endtask

  task automatic test_lock();
    xfer(1, fcl_pkg::SPI_SET_RDIS, 1, 15'h0023, 1);
    chk(rdis_o, 1);
    xfer(1, fcl_pkg::SPI_SET_RDIS, 1, 15'h0023, 0);
    xfer(1, fcl_pkg::SPI_READ, 0, 15'h0000, 0);
    xfer(1, fcl_pkg::SPI_READ, 1, 15'h0024, 1);
    xfer(1, fcl_pkg::SPI_WRITE, 0, 15'h0200, 0);
    xfer(1, fcl_pkg::fcl_spi_op_t'(3'h7), 1, 15'h0000, 0);
    xfer(1, fcl_pkg::SPI_READ, 1, 15'h0000, 1);
    xfer(1, fcl_pkg::SPI_ERASE_ALL, 0, 15'h0000, 1);
    chk({rdis_o, prot}, 16'h00FF);
    xfer(1, fcl_pkg::SPI_WRITE, 1, 15'h0000, 1);
    xfer(1, fcl_pkg::SPI_READ, 0, 15'h0000, 1);
    $display("test_lock done");
  endtask

  task automatic test_early();
    boot(8'hFF, 8'h00, 8'h00, 1'b1);
    cpu = '{1'b1, 1'b1, 15'h3E00};
    wait_resp();
    chk(cpu_r.grant, 1);
    chk({prot, rdis_o, dbg_en, jtag_en}, 16'h07FF);
    $display("test_early done");
  endtask

  initial begin
    test_prot();
    test_lock();
    test_early();
    test_done();
  end

  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
endmodule
